// [inc/start_gate_defs.svh]
// constants for the start gate and quadrature counter block
// assumes inclusion by bare name from the design file
`ifndef START_GATE_DEFS_SVH
`define START_GATE_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_CMD 12'h004
`define OFF_STAT 12'h008
`define OFF_POS1 12'h00C
`define OFF_POS2 12'h010
`define OFF_ZERO 12'h014

// ----------------------------------------
// field positions
// ----------------------------------------
// ctrl: [1:0] mode ch1, [2] ignore enable ch1, [5:4] mode ch2, [6] ign ch2
`define CTRL_CH_STRIDE 4
`define CTRL_IGN_BIT 2
// cmd: ch stride 4, [0] start, [1] dir plus, [2] dir minus, [3] stop
`define CMD_START_BIT 0
`define CMD_PLUS_BIT 1
`define CMD_MINUS_BIT 2
`define CMD_STOP_BIT 3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CTRL_RESET 32'h0000_0000
`define CLK_MHZ 50
`define SYNC_FAST_KHZ 500
`define SYNC_SLOW_KHZ 50
`define HW_SWITCH_US 150
`define HW_SWITCH_CYC (`HW_SWITCH_US * `CLK_MHZ)

`endif

// [inc/start_gate_pkg.sv]
// types for the start gate and quadrature counter block
// assumes the defines header sits beside it
package start_gate_pkg;
    // operating mode of one channel
    typedef enum logic [1:0] {
        MODE_JOG = 2'b00,
        MODE_REF_SEEK = 2'b01,
        MODE_ABS_INC = 2'b10,
        MODE_REL_INC = 2'b11
    } mode_t;

    // channel run state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PENDING = 2'b01,
        ST_RUN = 2'b10
    } state_t;

    // encoder pins of one channel
    typedef struct packed {
        logic trainA;
        logic trainB;
        logic zeroMark;
    } enc_t;
endpackage

// [verilog/start_gate_quadrature_count.sv]
// two-channel start gate with four-fold quadrature counting
// assumes apb master on sys_clk, encoder pins already synchronous
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "start_gate_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module start_gate_quadrature_count #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // enable inputs
    input wire logic ch1_start_release_input,
    input wire logic ch2_start_release_input,
    // encoders
    input wire start_gate_pkg::enc_t enc1,
    input wire start_gate_pkg::enc_t enc2,
    // motion outputs
    output logic [1:0] runActive,
    output logic [1:0] dirPlus,
    output logic [1:0] dirMinus,
    output logic [1:0] startPulse
);

    // ----------------------------------------
    // apb access
    // ----------------------------------------
    // register map, one aligned 32-bit word each, no byte enables:
    //   settings at the first word: mode and ignore-enable per channel
    //   command word: start, plus level, minus level, stop per channel
    //   status word: run state of both channels and both enable pins
    //   two position words: signed-wrapping quadrature counts
    //   zero word: sticky zero-mark flags, write one to clear
    // anything past the zero word or not word aligned answers with
    // pslverr; a write there is dropped and a read returns zero.
    //
    // transfer timing seen from the master:
    //   setup edge: psel high, penable low, nothing happens here
    //   first access edge: read data is latched, pready is raised
    //   pready edge: pready, prdata and pslverr are sampled and a
    //   write lands in its register at this edge and no other
    // writes wait for the pready edge so that a master which samples
    // the answer late still sees the register change with its answer.
    //
    // trade-off: a fixed single wait state keeps the slave trivially
    // simple at the cost of one extra cycle per access; the block is
    // slow-control only, so bus throughput does not matter here.
    logic [31:0] ctrl_q;
    logic [7:0] cmd_q;
    logic [1:0] zeroSeen_q;
    logic [CNT_W-1:0] pos_q [2];
    start_gate_pkg::state_t state_q [2];
    logic access;
    logic wrAcc;
    logic [1:0] chEnable;
    start_gate_pkg::enc_t enc [2];

    assign access = psel && penable && !pready;
    // write lands at the edge where the master samples pready
    assign wrAcc = psel && penable && pready && pwrite;
    assign chEnable = {ch2_start_release_input, ch1_start_release_input};
    assign enc[0] = enc1;
    assign enc[1] = enc2;

    // one wait state: pready rises in the cycle after the first access cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && (paddr > `OFF_ZERO || paddr[1:0] != 2'b00);
        end
    end

    // read mux, registered so prdata is valid with pready
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pwrite) begin
            case (paddr)
                `OFF_CTRL: prdata <= ctrl_q;
                `OFF_CMD: prdata <= {24'h00_0000, cmd_q};
                `OFF_STAT: prdata <= {24'h00_0000, chEnable, 2'b00,
                    2'(state_q[1]), 2'(state_q[0])};
                `OFF_POS1: prdata <= 32'(pos_q[0]);
                `OFF_POS2: prdata <= 32'(pos_q[1]);
                `OFF_ZERO: prdata <= {30'h0000_0000, zeroSeen_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end else if (access) begin
            // writes answer with zero data, so an error reply is clean
            prdata <= 32'h0000_0000;
        end
    end

    // settings register: mode and ignore-enable per channel
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wrAcc && paddr == `OFF_CTRL) begin
            ctrl_q <= {24'h00_0000, pwdata[7:0]};
        end
    end

    // command word behaviour:
    //   start and stop are strobes, they live for a single cycle after
    //   the write and then clear themselves, so a start is never
    //   applied twice by a stale bit
    //   plus and minus are levels, they stay as written until software
    //   writes the word again; jog runs only while one of them is held
    // limitation: a start written while the channel runs is ignored,
    // software must stop first and start again.
    // command register: start is self-clearing, direction levels are held
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd_q <= 8'h00;
        end else if (wrAcc && paddr == `OFF_CMD) begin
            cmd_q <= pwdata[7:0];
        end else begin
            cmd_q[`CMD_START_BIT] <= 1'b0;
            cmd_q[`CMD_START_BIT + `CTRL_CH_STRIDE] <= 1'b0;
            cmd_q[`CMD_STOP_BIT] <= 1'b0;
            cmd_q[`CMD_STOP_BIT + `CTRL_CH_STRIDE] <= 1'b0;
        end
    end

    // ----------------------------------------
    // per-channel start gate and counter
    // ----------------------------------------
    // start gate, one copy per channel:
    //   idle: nothing prepared; a start strobe or a jog level prepares
    //   pending: prepared, waiting for the channel enable pin
    //   run: mode active until stop, or until the jog level drops
    // the enable pin is looked at only when the ignore setting is off;
    // with the setting on a prepared mode starts at once, so there is
    // no way left to start at a hardware-defined moment.
    //
    // edge-started modes (reference seek, absolute and relative
    // increment) need a fresh start strobe each time; jog is level
    // driven and falls back to idle as soon as neither or both levels
    // are held. both levels held together counts as no level at all,
    // which keeps the motor from being told to go two ways at once.
    //
    // startPulse marks the cycle the mode really begins, one cycle
    // before runActive rises; downstream motion logic may use it to
    // latch its own set-points at the moment of start.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        start_gate_pkg::mode_t mode;
        logic ignoreEn;
        logic startCmd;
        logic stopCmd;
        logic plusLvl;
        logic minusLvl;
        logic released;
        logic [1:0] abPrev_q;
        logic zeroPrev_q;
        logic [1:0] ab;
        logic step;
        logic up;

        assign mode = start_gate_pkg::mode_t'(
            ctrl_q[c*`CTRL_CH_STRIDE +: 2]);
        assign ignoreEn = ctrl_q[c*`CTRL_CH_STRIDE + `CTRL_IGN_BIT];
        assign startCmd = cmd_q[c*`CTRL_CH_STRIDE + `CMD_START_BIT];
        assign stopCmd = cmd_q[c*`CTRL_CH_STRIDE + `CMD_STOP_BIT];
        assign plusLvl = cmd_q[c*`CTRL_CH_STRIDE + `CMD_PLUS_BIT];
        assign minusLvl = cmd_q[c*`CTRL_CH_STRIDE + `CMD_MINUS_BIT];
        // enable honoured unless the ignore setting is on
        assign released = ignoreEn || chEnable[c];

        // run state: prepared mode waits for release, jog follows levels
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                state_q[c] <= start_gate_pkg::ST_IDLE;
                startPulse[c] <= 1'b0;
            end else begin
                startPulse[c] <= 1'b0;
                case (state_q[c])
                    start_gate_pkg::ST_IDLE: begin
                        if (mode == start_gate_pkg::MODE_JOG) begin
                            // level-controlled: plus or minus held
                            if ((plusLvl ^ minusLvl) && released) begin
                                state_q[c] <= start_gate_pkg::ST_RUN;
                                startPulse[c] <= 1'b1;
                            end else if (plusLvl ^ minusLvl) begin
                                state_q[c] <= start_gate_pkg::ST_PENDING;
                            end
                        end else if (startCmd && released) begin
                            state_q[c] <= start_gate_pkg::ST_RUN;
                            startPulse[c] <= 1'b1;
                        end else if (startCmd) begin
                            state_q[c] <= start_gate_pkg::ST_PENDING;
                        end
                    end
                    start_gate_pkg::ST_PENDING: begin
                        if (stopCmd || (mode == start_gate_pkg::MODE_JOG &&
                                !(plusLvl ^ minusLvl))) begin
                            state_q[c] <= start_gate_pkg::ST_IDLE;
                        end else if (released) begin
                            state_q[c] <= start_gate_pkg::ST_RUN;
                            startPulse[c] <= 1'b1;
                        end
                    end
                    start_gate_pkg::ST_RUN: begin
                        // jog stops once the level is dropped
                        if (stopCmd || (mode == start_gate_pkg::MODE_JOG &&
                                !(plusLvl ^ minusLvl))) begin
                            state_q[c] <= start_gate_pkg::ST_IDLE;
                        end
                    end
                    default: state_q[c] <= start_gate_pkg::ST_IDLE;
                endcase
            end
        end

        // registered motion outputs
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                runActive[c] <= 1'b0;
                dirPlus[c] <= 1'b0;
                dirMinus[c] <= 1'b0;
            end else begin
                runActive[c] <= state_q[c] == start_gate_pkg::ST_RUN;
                // never both directions at once, even on the leaving edge
                dirPlus[c] <= state_q[c] == start_gate_pkg::ST_RUN &&
                    plusLvl && !minusLvl;
                dirMinus[c] <= state_q[c] == start_gate_pkg::ST_RUN &&
                    minusLvl && !plusLvl;
            end
        end

        // decoder notes:
        //   the pair {A, B} walks 00, 10, 11, 01 when A leads B
        //   each legal change flips exactly one train and is one step
        //   a change of both trains in one sample is a lost step; it is
        //   dropped rather than guessed, the count simply holds
        //   direction comes from old B against new A: they differ on
        //   every forward step and match on every backward step
        // hazard: the pins are taken as already synchronous; an encoder
        // wired straight to a pin needs its own synchroniser in front.
        // quadrature decode: one step per edge of either train; sampled
        // every 20 ns so 500 kHz input leaves ample margin
        assign ab = {enc[c].trainA, enc[c].trainB};
        assign step = ab != abPrev_q;
        // gray order 00-10-11-01 counts up (A leads B)
        assign up = abPrev_q[0] ^ ab[1];

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                abPrev_q <= 2'b00;
                zeroPrev_q <= 1'b0;
                pos_q[c] <= '0;
                zeroSeen_q[c] <= 1'b0;
            end else begin
                abPrev_q <= ab;
                zeroPrev_q <= enc[c].zeroMark;
                // count direct from pins, no frame latency
                if (step && ab != ~abPrev_q) begin
                    pos_q[c] <= up ? pos_q[c] + 1'b1 : pos_q[c] - 1'b1;
                end
                // zero mark latch: set wins over a software clear
                if (enc[c].zeroMark && !zeroPrev_q) begin
                    zeroSeen_q[c] <= 1'b1;
                end else if (wrAcc && paddr == `OFF_ZERO && pwdata[c]) begin
                    zeroSeen_q[c] <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// [verif/start_gate_properties.sv]
// checker for apb timing and start gate outputs
// assumes one clock domain and binding to the block top
`timescale 1ns/1ps
`default_nettype none
module sgq_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // motion side
    input wire logic [1:0] runActive,
    input wire logic [1:0] dirPlus,
    input wire logic [1:0] dirMinus,
    input wire logic [1:0] startPulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence apb_take;
        psel && penable && !pready;
    endsequence
    sequence pulse_run(i);
        startPulse[i] ##1 runActive[i];
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    apb_wait_a: assert property (apb_take |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_read_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer malformed");
    start_run_a: assert property (startPulse[0] |-> pulse_run(0))
        else $error("ch1 run missing after start");
    start_one_a: assert property (startPulse[0] |=> !startPulse[0])
        else $error("start pulse longer than one cycle");
    run_cause_a: assert property ($rose(runActive[0]) |-> $past(startPulse[0]))
        else $error("ch1 run without start pulse");
    jog_dir_a: assert property (dirPlus[0] |-> runActive[0] && !dirMinus[0])
        else $error("direction level without run");
    ch2_run_a: assert property (startPulse[1] |-> pulse_run(1))
        else $error("ch2 run missing after start");
endmodule
bind start_gate_quadrature_count sgq_checker chk (.sys_clk(sys_clk),
    .srst(srst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .runActive(runActive),
    .dirPlus(dirPlus), .dirMinus(dirMinus), .startPulse(startPulse));
`default_nettype wire

// [verif/quad_encoder_model.sv]
// incremental encoder model, one step per clock while asked
// assumes the counter samples every sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
    // clock
    input wire logic sys_clk,
    // step and zero requests
    input wire logic stepUp,
    input wire logic stepDown,
    input wire logic zeroReq,
    // encoder pins
    output wire start_gate_pkg::enc_t enc
);
    logic [1:0] phase_q = 2'b00;
    // walk 00,10,11,01 upward so train A leads train B
    always_ff @(posedge sys_clk) begin
        if (stepUp) begin
            phase_q <= phase_q + 2'b01;
        end else if (stepDown) begin
            phase_q <= phase_q - 2'b01;
        end
    end
    // only one train changes per step, a quarter period apart
    assign enc.trainA = phase_q[1] ^ phase_q[0];
    assign enc.trainB = phase_q[1];
    assign enc.zeroMark = zeroReq;
endmodule
`default_nettype wire

// [verif/start_gate_quadrature_count_tb.sv]
// testbench: apb register sequences and encoder steps
// assumes the design, package and encoder model are compiled first
`timescale 1ns/1ps
`default_nettype none
module start_gate_quadrature_count_tb;
    logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic ch1_start_release_input, ch2_start_release_input;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] runActive, dirPlus, dirMinus, startPulse, up, dn, zr;
    start_gate_pkg::enc_t enc1, enc2;
    int n_errors = 0;
    int compares = 0;
    start_gate_quadrature_count dut (.sys_clk(sys_clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc1(enc1), .enc2(enc2),
        .ch1_start_release_input(ch1_start_release_input),
        .ch2_start_release_input(ch2_start_release_input),
        .runActive(runActive), .dirPlus(dirPlus), .dirMinus(dirMinus),
        .startPulse(startPulse));
    quad_encoder_model e1 (.sys_clk(sys_clk), .stepUp(up[0]),
        .stepDown(dn[0]), .zeroReq(zr[0]), .enc(enc1));
    quad_encoder_model e2 (.sys_clk(sys_clk), .stepUp(up[1]),
        .stepDown(dn[1]), .zeroReq(zr[1]), .enc(enc2));
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is sampled
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(logic [11:0] a, logic [31:0] exp, string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask
    // moves an encoder n steps; steps land one per edge
    task automatic steps(int ch, logic upw, int n);
        up[ch] <= upw;
        dn[ch] <= !upw;
        repeat (n) @(posedge sys_clk);
        up[ch] <= 1'b0;
        dn[ch] <= 1'b0;
    endtask
    task automatic final_report;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ch1_start_release_input, ch2_start_release_input} = 2'b00;
        {up, dn, zr} = '0;
        srst = 1'b1;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        rdchk(12'h000, 32'h0000_0000, "ctrl reset");
        rdchk(12'h018, 32'h0000_0000, "unmapped read");
        check("unmapped error", err, 32'h0000_0001);
        $display("test reset done");
        // edge-started modes stay pending until enable comes on
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, 12'h000, m);
            apb(1'b1, 12'h004, 32'h0000_0001);
            rdchk(12'h008, 32'h0000_0001, "stat pending");
            check("run early", runActive, 32'h0000_0000);
            ch1_start_release_input <= 1'b1;
            repeat (4) @(posedge sys_clk);
            check("run ch1", runActive, 32'h0000_0001);
            apb(1'b1, 12'h004, 32'h0000_0008);
            ch1_start_release_input <= 1'b0;
        end
        $display("test pending start done");
        // ignore setting on ch2: starts with enable low
        apb(1'b1, 12'h000, 32'h0000_0060);
        apb(1'b1, 12'h004, 32'h0000_0010);
        repeat (4) @(posedge sys_clk);
        check("run ch2", runActive, 32'h0000_0002);
        rdchk(12'h008, 32'h0000_0008, "stat ch2 run");
        apb(1'b1, 12'h004, 32'h0000_0080);
        $display("test ignore enable done");
        // jog: plus, minus, both refused; runs only while held
        ch1_start_release_input <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h004, (i + 1) * 2);
            repeat (4) @(posedge sys_clk);
            check("jog dir", {dirPlus[0], dirMinus[0]}, {i == 0, i == 1});
            apb(1'b1, 12'h004, 32'h0000_0000);
            repeat (4) @(posedge sys_clk);
            check("jog released", runActive, 32'h0000_0000);
        end
        $display("test jog done");
        // four-fold counting in both directions, wrap below zero
        steps(0, 1'b1, 8);
        rdchk(12'h00C, 32'h0000_0008, "pos1 up");
        steps(0, 1'b0, 3);
        rdchk(12'h00C, 32'h0000_0005, "pos1 down");
        steps(1, 1'b0, 1);
        rdchk(12'h010, 32'hFFFF_FFFF, "pos2 wrap");
        zr <= 2'b11;
        @(posedge sys_clk);
        zr <= 2'b00;
        apb(1'b0, 12'h014, 32'h0000_0000);
        check("zero seen", rd, 32'h0000_0003);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        rdchk(12'h014, 32'h0000_0000, "zero cleared");
        $display("test encoder done");
        final_report();
    end
endmodule
`default_nettype wire
